// ---- logic/cgb_defines.svh ----
// Register offsets, field positions and reset values of the clock gate bank
`ifndef CGB_DEFINES_SVH
`define CGB_DEFINES_SVH

`define CGB_OFF_SYS_EN       8'h00
`define CGB_OFF_SYS_DIS      8'h04
`define CGB_OFF_SYS_STATE    8'h08
`define CGB_OFF_PER_EN       8'h10
`define CGB_OFF_PER_DIS      8'h14
`define CGB_OFF_PER_STATE    8'h18
`define CGB_OFF_OSC_CTRL     8'h20
`define CGB_OFF_MAIN_FREQ    8'h24
`define CGB_OFF_PLL_CTRL     8'h2c
`define CGB_OFF_MCLK_SEL     8'h30
`define CGB_OFF_PCLK0_CFG    8'h40
`define CGB_OFF_PCLK1_CFG    8'h44
`define CGB_OFF_IRQ_SET      8'h60
`define CGB_OFF_IRQ_CLR      8'h64
`define CGB_OFF_PWR_STATUS   8'h68
`define CGB_OFF_IRQ_MASK     8'h6c

`define CGB_CPU_CLOCK_BIT    0
`define CGB_USB_PORT_BIT     7
`define CGB_PROG_CLK_LO      8
`define CGB_PROG_CLK_HI      10
`define CGB_PER_LO           2

`define CGB_SYS_MASK         32'h0000_0781
`define CGB_SYS_RESET        32'h0000_0001
`define CGB_PER_MASK         32'hffff_fffc
`define CGB_PER_RESET        32'h0000_0000
`define CGB_PLL_RESET        32'h0000_3f00
`define CGB_PWR_STAT_RESET   32'h0000_0008

`endif

// ---- logic/cgb_pkg.sv ----
// Types shared by the clock gate bank
package cgb_pkg;
  typedef enum logic [1:0] {
    CGB_IDLE,
    CGB_ANSWER
  } cgb_bus_state_t;
endpackage

// ---- logic/cgb_clock_gate_bank.sv ----
// Clock gate enable bank with power manager register map over Avalon-MM
// Function
// - Writing one to enable bit 0 starts the processor clock; zero changes nothing.
// - Writing one to disable bit 0 stops the processor clock, entering idle.
// - Writing one to enable bit 7 starts the 48 MHz USB port clock.
// - Writing one to disable bit 7 stops the 48 MHz USB port clock.
// - Ones in enable bits 8 to 10 turn on programmable clock outputs.
// - Ones in disable bits 8 to 10 turn off programmable clock outputs.
// - System state bit 0 shows the processor clock; reset value is 0x01.
// - System state bit 7 shows whether the USB port clock is enabled.
// - System state bits 8 to 10 show programmable clock output enables.
// - Ones in peripheral enable bits 2 to 31 start those clocks; 0,1 absent.
// - Ones in peripheral disable bits 2 to 31 stop those clocks.
// - Bits of absent peripherals never alter any behaviour of the block.
// - System enable, disable, state sit at 0x00, 0x04, 0x08; WO, WO, RO.
// - Peripheral enable, disable, state sit at 0x10, 0x14, 0x18; state resets 0.
// - Each implemented peripheral state bit reads its clock's enable.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "cgb_defines.svh"

module cgb_clock_gate_bank
  import cgb_pkg::*;
#(
  parameter logic [31:0] PER_PRESENT = 32'hffff_fffc
)
(
  input  wire logic        core_clk_in,
  input  wire logic        nrst_in,
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic             cpu_clock_en_out,
  output logic             usb_port_clock_en_out,
  output logic [2:0]       prog_clock_en_out,
  output logic [31:0]      periph_clock_en_out,
  output logic [31:0]      mclk_sel_out,
  output logic [31:0]      pclk0_cfg_out,
  output logic [31:0]      pclk1_cfg_out,
  output logic [31:0]      osc_ctrl_out,
  output logic [31:0]      pll_ctrl_out
);

  cgb_bus_state_t bus_state_reg;
  logic [31:0]    sys_state_reg;
  logic [31:0]    per_state_reg;
  logic [31:0]    osc_ctrl_reg;
  logic [31:0]    pll_ctrl_reg;
  logic [31:0]    mclk_sel_reg;
  logic [31:0]    pclk0_reg;
  logic [31:0]    pclk1_reg;
  logic [31:0]    irq_mask_reg;
  logic [31:0]    readdata_reg;
  logic [31:0]    readdata_next;
  logic [31:0]    wmask;
  logic [31:0]    wdata;
  logic           wr_take;
  logic           rd_take;
  logic           wr_reserved;

  // Byte enables turned into a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Masked read-modify-write for plain read/write registers
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  // Offsets that accept writes; all others are reserved or read-only
  function automatic logic writable_offset(input logic [7:0] a);
    unique case (a)
      `CGB_OFF_SYS_EN, `CGB_OFF_SYS_DIS, `CGB_OFF_PER_EN, `CGB_OFF_PER_DIS:
        writable_offset = 1'h1;
      `CGB_OFF_OSC_CTRL, `CGB_OFF_PLL_CTRL, `CGB_OFF_MCLK_SEL:
        writable_offset = 1'h1;
      `CGB_OFF_PCLK0_CFG, `CGB_OFF_PCLK1_CFG, `CGB_OFF_IRQ_SET, `CGB_OFF_IRQ_CLR:
        writable_offset = 1'h1;
      default:
        writable_offset = 1'h0;
    endcase
  endfunction

  // Requests are taken in the idle state and answered one cycle later
  assign wr_take = avs_write_in && (bus_state_reg == CGB_IDLE);
  assign rd_take = avs_read_in && (bus_state_reg == CGB_IDLE);
  assign wmask   = lane_mask(avs_byteenable_in);
  assign wdata   = avs_writedata_in & wmask;
  assign wr_reserved = wr_take && !writable_offset(avs_address_in);

  // Bus handshake: waitrequest high except in the answer cycle
  // Answer goes straight back to idle, which takes the next request; a request still held at the
  // answer edge is never taken a second time, since the answer state takes nothing
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      bus_state_reg       <= CGB_IDLE;
      avs_waitrequest_out <= 1'b1;
    end
    else
    begin
      unique case (bus_state_reg)
        CGB_IDLE:
        begin
          if (wr_take || rd_take)
          begin
            bus_state_reg       <= CGB_ANSWER;
            avs_waitrequest_out <= 1'b0;
          end
        end
        CGB_ANSWER:
        begin
          bus_state_reg       <= CGB_IDLE;
          avs_waitrequest_out <= 1'b1;
        end
      endcase
    end
  end

  // System clock gates, set and clear by separate write-only registers
  // One write per cycle, so a set and a clear never meet
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      sys_state_reg <= `CGB_SYS_RESET;
    else if (wr_take && avs_address_in == `CGB_OFF_SYS_EN)
      sys_state_reg <= sys_state_reg | (wdata & `CGB_SYS_MASK);
    else if (wr_take && avs_address_in == `CGB_OFF_SYS_DIS)
      sys_state_reg <= sys_state_reg & ~(wdata & `CGB_SYS_MASK);
  end

  // Peripheral clock gates; absent identifiers are masked away
  // PER_PRESENT marks the identifiers that exist in this build
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      per_state_reg <= `CGB_PER_RESET;
    else if (wr_take && avs_address_in == `CGB_OFF_PER_EN)
      per_state_reg <= per_state_reg | (wdata & `CGB_PER_MASK & PER_PRESENT);
    else if (wr_take && avs_address_in == `CGB_OFF_PER_DIS)
      per_state_reg <= per_state_reg & ~(wdata & `CGB_PER_MASK & PER_PRESENT);
  end

  // Mapped configuration registers, stored for the neighbouring blocks; the interrupt mask is only read back
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      osc_ctrl_reg <= '0;
      pll_ctrl_reg <= `CGB_PLL_RESET;
      mclk_sel_reg <= '0;
      pclk0_reg    <= '0;
      pclk1_reg    <= '0;
      irq_mask_reg <= '0;
    end
    else if (wr_take)
    begin
      unique case (avs_address_in)
        `CGB_OFF_OSC_CTRL:  osc_ctrl_reg <= merge(osc_ctrl_reg, avs_writedata_in, wmask);
        `CGB_OFF_PLL_CTRL:  pll_ctrl_reg <= merge(pll_ctrl_reg, avs_writedata_in, wmask);
        `CGB_OFF_MCLK_SEL:  mclk_sel_reg <= merge(mclk_sel_reg, avs_writedata_in, wmask);
        `CGB_OFF_PCLK0_CFG: pclk0_reg    <= merge(pclk0_reg, avs_writedata_in, wmask);
        `CGB_OFF_PCLK1_CFG: pclk1_reg    <= merge(pclk1_reg, avs_writedata_in, wmask);
        `CGB_OFF_IRQ_SET:   irq_mask_reg <= irq_mask_reg | wdata;
        `CGB_OFF_IRQ_CLR:   irq_mask_reg <= irq_mask_reg & ~wdata;
        default:            irq_mask_reg <= irq_mask_reg;
      endcase
    end
  end

  // Read decode
  always_comb
  begin
    readdata_next = '0;
    unique case (avs_address_in)
      `CGB_OFF_SYS_STATE:  readdata_next = sys_state_reg;
      `CGB_OFF_PER_STATE:  readdata_next = per_state_reg;
      `CGB_OFF_OSC_CTRL:   readdata_next = osc_ctrl_reg;
      `CGB_OFF_PLL_CTRL:   readdata_next = pll_ctrl_reg;
      `CGB_OFF_MCLK_SEL:   readdata_next = mclk_sel_reg;
      `CGB_OFF_PCLK0_CFG:  readdata_next = pclk0_reg;
      `CGB_OFF_PCLK1_CFG:  readdata_next = pclk1_reg;
      `CGB_OFF_PWR_STATUS: readdata_next = `CGB_PWR_STAT_RESET;
      `CGB_OFF_IRQ_MASK:   readdata_next = irq_mask_reg;
      default:             readdata_next = '0;
    endcase
  end

  // Read data register, valid in the answer cycle
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      readdata_reg <= '0;
    else if (rd_take)
      readdata_reg <= readdata_next;
  end

  assign avs_readdata_out = readdata_reg;

  // Gate outputs, registered copies of the state
  // Extra stage keeps every output on a flop; gates move at the edge
  // that ends the answer cycle of the write
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cpu_clock_en_out      <= 1'b1;
      usb_port_clock_en_out <= 1'b0;
      prog_clock_en_out     <= '0;
      periph_clock_en_out   <= '0;
      mclk_sel_out          <= '0;
      pclk0_cfg_out         <= '0;
      pclk1_cfg_out         <= '0;
      osc_ctrl_out          <= '0;
      pll_ctrl_out          <= `CGB_PLL_RESET;
    end
    else
    begin
      cpu_clock_en_out      <= sys_state_reg[`CGB_CPU_CLOCK_BIT];
      usb_port_clock_en_out <= sys_state_reg[`CGB_USB_PORT_BIT];
      prog_clock_en_out     <= sys_state_reg[`CGB_PROG_CLK_HI:`CGB_PROG_CLK_LO];
      periph_clock_en_out   <= per_state_reg;
      mclk_sel_out          <= mclk_sel_reg;
      pclk0_cfg_out         <= pclk0_reg;
      pclk1_cfg_out         <= pclk1_reg;
      osc_ctrl_out          <= osc_ctrl_reg;
      pll_ctrl_out          <= pll_ctrl_reg;
    end
  end

  a_cpu_clk_on: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    wr_take && avs_address_in == `CGB_OFF_SYS_EN && wdata[0] |=> ##1 cpu_clock_en_out)
    else $error("processor clock not enabled");

  a_cpu_clk_off: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    wr_take && avs_address_in == `CGB_OFF_SYS_DIS && wdata[0] |=> ##1 !cpu_clock_en_out)
    else $error("processor clock not stopped");

  a_usb_clk_set: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    wr_take && avs_address_in == `CGB_OFF_SYS_EN && wdata[7] |=> sys_state_reg[7])
    else $error("usb clock not set");
  a_usb_clk_clr: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    wr_take && avs_address_in == `CGB_OFF_SYS_DIS && wdata[7] |=> !sys_state_reg[7])
    else $error("usb clock not cleared");

  a_prog_clk_set: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    wr_take && avs_address_in == `CGB_OFF_SYS_EN |=>
      (sys_state_reg[10:8] & $past(wdata[10:8])) == $past(wdata[10:8]))
    else $error("programmable clock not set");
  a_prog_clk_clr: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    wr_take && avs_address_in == `CGB_OFF_SYS_DIS |=> (sys_state_reg[10:8] & $past(wdata[10:8])) == 3'h0)
    else $error("programmable clock not cleared");

  a_sys_readback: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    rd_take && avs_address_in == `CGB_OFF_SYS_STATE |=> avs_readdata_out == $past(sys_state_reg))
    else $error("system state readback wrong");

  a_per_clk_set: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    wr_take && avs_address_in == `CGB_OFF_PER_EN |=> ##1
      (periph_clock_en_out & $past(wdata, 2) & PER_PRESENT & `CGB_PER_MASK) ==
      ($past(wdata, 2) & PER_PRESENT & `CGB_PER_MASK))
    else $error("peripheral clock not set");
  a_per_clk_clr: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    wr_take && avs_address_in == `CGB_OFF_PER_DIS |=> (per_state_reg & $past(wdata) & PER_PRESENT) == '0)
    else $error("peripheral clock not cleared");

  a_per_absent: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (per_state_reg & ~(PER_PRESENT & `CGB_PER_MASK)) == '0)
    else $error("absent peripheral bit set");

  a_wo_reads_zero: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    rd_take && (avs_address_in == `CGB_OFF_SYS_EN || avs_address_in == `CGB_OFF_PER_DIS)
      |=> avs_readdata_out == '0)
    else $error("write-only register read nonzero");

  // one wait cycle, one answer cycle
  a_bus_answer: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    wr_take || rd_take |=> !avs_waitrequest_out)
    else $error("request not answered");
  a_bus_single: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    !avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("answer held too long");

  a_rdata_hold: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    !rd_take |=> $stable(avs_readdata_out))
    else $error("read data changed without a read");

  a_per_readback: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    rd_take && avs_address_in == `CGB_OFF_PER_STATE |=> avs_readdata_out == $past(per_state_reg))
    else $error("peripheral state readback wrong");

  a_per_low_bits: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    periph_clock_en_out[1:0] == 2'h0)
    else $error("unimplemented peripheral gate on");

  a_sys_bits_legal: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (sys_state_reg & ~`CGB_SYS_MASK) == '0)
    else $error("unimplemented system state bit set");

  a_reserved_wr_ignored: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    wr_reserved |=> $stable(sys_state_reg) && $stable(per_state_reg) && $stable(osc_ctrl_reg) &&
      $stable(pll_ctrl_reg) && $stable(mclk_sel_reg) && $stable(pclk0_reg) && $stable(pclk1_reg) &&
      $stable(irq_mask_reg))
    else $error("reserved write changed state");

  a_cpu_out_track: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    cpu_clock_en_out == $past(sys_state_reg[`CGB_CPU_CLOCK_BIT]))
    else $error("processor gate output stale");
  a_usb_out_track: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    usb_port_clock_en_out == $past(sys_state_reg[`CGB_USB_PORT_BIT]))
    else $error("usb gate output stale");
  a_prog_out_track: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    prog_clock_en_out == $past(sys_state_reg[`CGB_PROG_CLK_HI:`CGB_PROG_CLK_LO]))
    else $error("programmable gate output stale");
  a_per_out_track: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    periph_clock_en_out == $past(per_state_reg))
    else $error("peripheral gate output stale");

endmodule

// ---- testbench/tb.sv ----
// Self-checking testbench for the clock gate bank register interface
`timescale 1ns/1ps
module tb;
  import cgb_pkg::*;
  // Bit 31 marked absent to exercise unimplemented peripherals
  localparam logic [31:0] PRES = 32'h7fff_fffc;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] data;
    logic [31:0] sys;
    logic [31:0] per;
  } cgb_row_t;

  logic        core_clk_in;
  logic        nrst_in;
  logic [7:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        waitreq;
  logic        cpu_en;
  logic        usb_en;
  logic [2:0]  prog_en;
  logic [31:0] per_en;
  logic [31:0] pll_cfg;
  logic [31:0] mclk_sel;
  logic [31:0] pclk0_cfg;
  logic [31:0] pclk1_cfg;
  logic [31:0] osc_cfg;
  logic [3:0]  be;
  logic [31:0] q;
  int          n_errors;
  int          num_checks;

  // Writes and expected state after each, applied in order
  cgb_row_t rows [13] = '{
    '{8'h00, 32'hffff_ffff, 32'h0000_0781, 32'h0000_0000},
    '{8'h04, 32'h0000_0001, 32'h0000_0780, 32'h0000_0000},
    '{8'h00, 32'h0000_0000, 32'h0000_0780, 32'h0000_0000},
    '{8'h04, 32'h0000_0500, 32'h0000_0280, 32'h0000_0000},
    '{8'h04, 32'h0000_0080, 32'h0000_0200, 32'h0000_0000},
    '{8'h00, 32'h0000_0001, 32'h0000_0201, 32'h0000_0000},
    '{8'h10, 32'hffff_ffff, 32'h0000_0201, 32'h7fff_fffc},
    '{8'h14, 32'h0000_0110, 32'h0000_0201, 32'h7fff_feec},
    '{8'h10, 32'h0000_0000, 32'h0000_0201, 32'h7fff_feec},
    '{8'h0c, 32'hffff_ffff, 32'h0000_0201, 32'h7fff_feec},
    '{8'h08, 32'hffff_0000, 32'h0000_0201, 32'h7fff_feec},
    '{8'h18, 32'h0000_0000, 32'h0000_0201, 32'h7fff_feec},
    '{8'h14, 32'hffff_fffc, 32'h0000_0201, 32'h0000_0000}
  };
  // Offsets that must read as zero
  logic [7:0] zero_addr [8] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h1c, 8'h70, 8'hfc};
  // Readback after the config writes: address, then value
  logic [39:0] rd_rows [8] = '{40'h30_0000_0007, 40'h40_0000_001c, 40'h44_0000_0006, 40'h20_0000_ff01,
                               40'h2c_0001_2345, 40'h6c_0000_0008, 40'h68_0000_0008, 40'h24_0000_0000};

  cgb_clock_gate_bank #(
    .PER_PRESENT (PRES)
  ) uut (
    .core_clk_in           (core_clk_in),
    .nrst_in               (nrst_in),
    .avs_address_in        (addr),
    .avs_read_in           (rd),
    .avs_write_in          (wr),
    .avs_writedata_in      (wdata),
    .avs_byteenable_in     (be),
    .avs_readdata_out      (rdata),
    .avs_waitrequest_out   (waitreq),
    .cpu_clock_en_out      (cpu_en),
    .usb_port_clock_en_out (usb_en),
    .prog_clock_en_out     (prog_en),
    .periph_clock_en_out   (per_en),
    .mclk_sel_out          (mclk_sel),
    .pclk0_cfg_out         (pclk0_cfg),
    .pclk1_cfg_out         (pclk1_cfg),
    .osc_ctrl_out          (osc_cfg),
    .pll_ctrl_out          (pll_cfg)
  );

  // Clock generation, 5 ns period
  always #2.5 core_clk_in = ~core_clk_in;

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Compare one value against its expectation
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus transfer, held until waitrequest is sampled low
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge core_clk_in);
    while (waitreq !== 1'b0)
    begin
      if (n == 50)
      begin
        n_errors++;
        $display("unexpected at %0t: bus timeout", $time);
        end_sim();
      end
      n++;
      @(posedge core_clk_in);
    end
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge core_clk_in);
  endtask

  // Status reads plus gate outputs against expectation
  task automatic chk_state(input logic [31:0] s, input logic [31:0] p);
    logic [31:0] v;
    xfer(1'b0, 8'h08, 32'h0, v);
    chk(v, s);
    xfer(1'b0, 8'h18, 32'h0, v);
    chk(v, p);
    chk({21'h0, prog_en, usb_en, 6'h0, cpu_en}, s);
    chk(per_en, p);
  endtask

  // Main sequence
  initial
  begin
    core_clk_in = 1'b0;
    nrst_in = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    be = 4'hf;
    n_errors = 0;
    num_checks = 0;
    repeat (6) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    @(posedge core_clk_in);
    chk(pll_cfg, 32'h0000_3f00);
    chk_state(32'h0000_0001, 32'h0);
    $display("test reset values done");
    foreach (rows[i])
    begin
      xfer(1'b1, rows[i].addr, rows[i].data, q);
      chk_state(rows[i].sys, rows[i].per);
    end
    $display("test gate table done");
    foreach (zero_addr[i])
    begin
      xfer(1'b0, zero_addr[i], 32'h0, q);
      chk(q, 32'h0);
    end
    $display("test zero reads done");
    // Mapped registers, mask set and clear, fixed status word
    xfer(1'b1, 8'h30, 32'h0000_0007, q);
    xfer(1'b1, 8'h40, 32'h0000_001c, q);
    xfer(1'b1, 8'h44, 32'h0000_0006, q);
    xfer(1'b1, 8'h20, 32'h0000_ff01, q);
    xfer(1'b1, 8'h2c, 32'h0001_2345, q);
    xfer(1'b1, 8'h60, 32'h0000_0009, q);
    xfer(1'b1, 8'h64, 32'h0000_0001, q);
    xfer(1'b1, 8'h68, 32'hffff_ffff, q);
    chk(mclk_sel, 32'h0000_0007);
    chk(pclk0_cfg, 32'h0000_001c);
    chk(pclk1_cfg, 32'h0000_0006);
    chk(osc_cfg, 32'h0000_ff01);
    chk(pll_cfg, 32'h0001_2345);
    foreach (rd_rows[i])
    begin
      xfer(1'b0, rd_rows[i][39:32], 32'h0, q);
      chk(q, rd_rows[i][31:0]);
    end
    // Only the low byte lane reaches the disable register
    be <= 4'h1;
    xfer(1'b1, 8'h04, 32'h0000_0781, q);
    be <= 4'hf;
    chk_state(32'h0000_0200, 32'h0);
    $display("test mapped registers and byte lanes done");
    xfer(1'b1, 8'h10, 32'h0000_00f0, q);
    xfer(1'b1, 8'h04, 32'h0000_0201, q);
    chk_state(32'h0000_0000, 32'h0000_00f0);
    nrst_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    chk({31'h0, waitreq}, 32'h1);
    nrst_in <= 1'b1;
    @(posedge core_clk_in);
    chk_state(32'h0000_0001, 32'h0);
    chk(pll_cfg, 32'h0000_3f00);
    chk(mclk_sel, 32'h0);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule
